// ---- rtl/iopc_check.sv ----
// module: io port permission checker with wishbone registers
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module iopc_check #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // request from instruction execution
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [15:0] req_port,
  input wire logic [1:0] req_size,
  input wire logic [7:0] req_vector,
  input wire logic [3:0] req_stack_index,
  input wire logic req_v86,
  input wire logic [1:0] req_cpl,
  input wire logic [1:0] req_io_privilege_level,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_fault,
  output logic rsp_redirect,
  output logic [63:0] rsp_data,
  // byte read port to system memory
  output logic mem_rd_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic irq
);
  // address datapath is fixed at 32 bits
  if (ADDR_W != 32) begin : g_addr_w_check
    $error("iopc_check: ADDR_W must be 32");
  end

  iopc_pkg::iopc_state_t state_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] tss_base_reg;
  logic [31:0] tss_limit_reg;
  logic [2:0] irq_enable_reg;
  logic [2:0] irq_clear;
  logic [2:0] irq_status;
  logic [2:0] irq_event;
  logic irq_out;
  logic [31:0] wb_dat_reg;
  logic wb_ack_reg;
  logic [31:0] fault_count_reg;
  logic [15:0] last_port_reg;

  logic [1:0] kind_reg;
  logic [15:0] port_reg;
  logic [1:0] size_reg;
  logic [7:0] vector_reg;
  logic [7:0] base_lo_reg;
  logic [7:0] map_lo_reg;
  logic [2:0] byte_cnt_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic rsp_fault_reg;
  logic rsp_redirect_reg;
  logic [63:0] rsp_data_reg;
  logic mem_rd_req_reg;
  logic [31:0] mem_addr_reg;
  logic result_fault_reg;
  logic result_redirect_reg;
  logic base_over_reg;

  logic wb_hit;
  logic need_check;
  logic [15:0] map_off;
  logic [16:0] port_byte_off;
  logic [16:0] redir_byte_off;
  logic [16:0] byte_off;
  logic [31:0] stack_off;
  logic base_over;
  logic past_limit;
  logic stack_past_limit;
  logic deny;

  // request decode
  assign need_check = req_v86 || (req_cpl > req_io_privilege_level);
  assign map_off = {mem_rdata, base_lo_reg};
  assign port_byte_off = {1'b0, map_off} + {4'h0, port_reg[15:3]};
  // redirection bitmap ends where the io bitmap starts
  assign redir_byte_off = {1'b0, map_off} - iopc_pkg::REDIR_MAP_BYTES + {12'h000, vector_reg[7:3]};
  assign byte_off = (kind_reg == iopc_pkg::KIND_REDIR) ? redir_byte_off : port_byte_off;
  assign base_over = ctrl_reg[iopc_pkg::CTRL_ALL_PORTS_BIT] && (map_off > iopc_pkg::MAP_BASE_MAX);
  // the second fetched byte must lie inside the limit too
  assign past_limit = ({15'h0000, byte_off} + 32'h0000_0001) > tss_limit_reg;
  always_comb begin
    if (req_stack_index < iopc_pkg::PRIV_STACK_COUNT) begin
      stack_off = iopc_pkg::TSS_PRIV_STACK_OFF + {25'h0000000, req_stack_index, 3'h0};
    end else begin
      stack_off = iopc_pkg::TSS_INT_STACK_OFF +
        {25'h0000000, 4'(req_stack_index - iopc_pkg::PRIV_STACK_COUNT), 3'h0};
    end
  end
  assign stack_past_limit = ((stack_off + {29'h0, iopc_pkg::STACK_LAST_BYTE}) > tss_limit_reg) ||
    (req_stack_index > iopc_pkg::STACK_INDEX_MAX);

  iopc_perm_eval u_eval (
    .map_word({mem_rdata, map_lo_reg}),
    .bit_sel(port_reg[2:0]),
    .size(size_reg),
    .deny(deny)
  );

  // checking sequence; stack reads stay within the first 104 bytes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= iopc_pkg::ST_IDLE;
      kind_reg <= 2'h0;
      port_reg <= 16'h0000;
      size_reg <= 2'h0;
      vector_reg <= 8'h00;
      base_lo_reg <= 8'h00;
      map_lo_reg <= 8'h00;
      byte_cnt_reg <= 3'h0;
      mem_rd_req_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
      result_fault_reg <= 1'b0;
      result_redirect_reg <= 1'b0;
      base_over_reg <= 1'b0;
      rsp_data_reg <= 64'h0000_0000_0000_0000;
    end else begin
      case (state_reg)
        iopc_pkg::ST_IDLE: begin
          base_over_reg <= 1'b0;
          if (req_valid) begin
            kind_reg <= req_kind;
            port_reg <= req_port;
            size_reg <= req_size;
            vector_reg <= req_vector;
            result_fault_reg <= 1'b0;
            result_redirect_reg <= 1'b0;
            byte_cnt_reg <= 3'h0;
            if (req_kind == iopc_pkg::KIND_STACK) begin
              if (stack_past_limit) begin
                result_fault_reg <= 1'b1;
                state_reg <= iopc_pkg::ST_DONE;
              end else begin
                mem_addr_reg <= tss_base_reg + stack_off;
                mem_rd_req_reg <= 1'b1;
                state_reg <= iopc_pkg::ST_STACK;
              end
            end else if (req_kind == iopc_pkg::KIND_PORT &&
                (!need_check || !ctrl_reg[iopc_pkg::CTRL_CHECK_EN_BIT])) begin
              state_reg <= iopc_pkg::ST_DONE;
            end else begin
              mem_addr_reg <= tss_base_reg + iopc_pkg::TSS_MAP_BASE_OFF;
              mem_rd_req_reg <= 1'b1;
              state_reg <= iopc_pkg::ST_BASE_LO;
            end
          end
        end
        iopc_pkg::ST_BASE_LO: begin
          if (mem_ack) begin
            base_lo_reg <= mem_rdata;
            mem_addr_reg <= mem_addr_reg + 32'h0000_0001;
            state_reg <= iopc_pkg::ST_BASE_HI;
          end
        end
        iopc_pkg::ST_BASE_HI: begin
          if (mem_ack) begin
            if (kind_reg == iopc_pkg::KIND_PORT && base_over) begin
              base_over_reg <= 1'b1;
              result_fault_reg <= 1'b1;
              mem_rd_req_reg <= 1'b0;
              state_reg <= iopc_pkg::ST_DONE;
            end else if (past_limit ||
                (kind_reg == iopc_pkg::KIND_REDIR && map_off < iopc_pkg::REDIR_MAP_BYTES[15:0])) begin
              result_fault_reg <= 1'b1;
              mem_rd_req_reg <= 1'b0;
              state_reg <= iopc_pkg::ST_DONE;
            end else begin
              mem_addr_reg <= tss_base_reg + {15'h0000, byte_off};
              state_reg <= iopc_pkg::ST_MAP_LO;
            end
          end
        end
        iopc_pkg::ST_MAP_LO: begin
          if (mem_ack) begin
            map_lo_reg <= mem_rdata;
            if (kind_reg == iopc_pkg::KIND_REDIR) begin
              result_redirect_reg <= mem_rdata[vector_reg[2:0]];
              mem_rd_req_reg <= 1'b0;
              state_reg <= iopc_pkg::ST_DONE;
            end else begin
              mem_addr_reg <= mem_addr_reg + 32'h0000_0001;
              state_reg <= iopc_pkg::ST_MAP_HI;
            end
          end
        end
        iopc_pkg::ST_MAP_HI: begin
          if (mem_ack) begin
            result_fault_reg <= deny;
            mem_rd_req_reg <= 1'b0;
            state_reg <= iopc_pkg::ST_DONE;
          end
        end
        iopc_pkg::ST_STACK: begin
          if (mem_ack) begin
            // little endian, first byte lands lowest after eight shifts
            rsp_data_reg <= {mem_rdata, rsp_data_reg[63:8]};
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
            mem_addr_reg <= mem_addr_reg + 32'h0000_0001;
            if (byte_cnt_reg == iopc_pkg::STACK_LAST_BYTE) begin
              mem_rd_req_reg <= 1'b0;
              state_reg <= iopc_pkg::ST_DONE;
            end
          end
        end
        iopc_pkg::ST_DONE: begin
          state_reg <= iopc_pkg::ST_IDLE;
        end
        default: begin
          mem_rd_req_reg <= 1'b0;
          state_reg <= iopc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // answer to the execution logic, one cycle pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_fault_reg <= 1'b0;
      rsp_redirect_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= (state_reg == iopc_pkg::ST_DONE);
      ready_reg <= (state_reg == iopc_pkg::ST_IDLE) && !req_valid;
      if (state_reg == iopc_pkg::ST_DONE) begin
        rsp_fault_reg <= result_fault_reg;
        rsp_redirect_reg <= result_redirect_reg;
      end
    end
  end

  // fault bookkeeping for software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_count_reg <= 32'h0000_0000;
      last_port_reg <= 16'h0000;
    end else if (state_reg == iopc_pkg::ST_DONE && result_fault_reg) begin
      fault_count_reg <= fault_count_reg + 32'h0000_0001;
      last_port_reg <= port_reg;
    end
  end

  assign irq_event[iopc_pkg::IRQ_FAULT_BIT] = (state_reg == iopc_pkg::ST_DONE) && result_fault_reg;
  assign irq_event[iopc_pkg::IRQ_BASE_OVER_BIT] = (state_reg == iopc_pkg::ST_DONE) && base_over_reg;
  assign irq_event[iopc_pkg::IRQ_DONE_BIT] = (state_reg == iopc_pkg::ST_DONE);

  iopc_irq #(
    .N(iopc_pkg::IRQ_COUNT)
  ) u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .event_set(irq_event),
    .clear(irq_clear),
    .enable(irq_enable_reg),
    .status(irq_status),
    .irq(irq_out)
  );

  // wishbone: ack one cycle after the strobe, dropped the cycle after
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_reg;
  assign irq_clear = (wb_hit && wb_we_i && wb_adr_i == iopc_pkg::REG_IRQ_CLEAR && wb_sel_i[0]) ?
    wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= iopc_pkg::CTRL_RESET;
      tss_base_reg <= 32'h0000_0000;
      tss_limit_reg <= iopc_pkg::TSS_LIMIT_RESET;
      irq_enable_reg <= 3'h0;
    end else if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        iopc_pkg::REG_CTRL: begin
          if (wb_sel_i[0]) ctrl_reg <= wb_dat_i[1:0];
        end
        iopc_pkg::REG_TSS_BASE: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) tss_base_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
        iopc_pkg::REG_TSS_LIMIT: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) tss_limit_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
        iopc_pkg::REG_IRQ_ENABLE: begin
          if (wb_sel_i[0]) irq_enable_reg <= wb_dat_i[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          iopc_pkg::REG_CTRL: wb_dat_reg <= {30'h0, ctrl_reg};
          iopc_pkg::REG_TSS_BASE: wb_dat_reg <= tss_base_reg;
          iopc_pkg::REG_TSS_LIMIT: wb_dat_reg <= tss_limit_reg;
          iopc_pkg::REG_IRQ_STATUS: wb_dat_reg <= {29'h0, irq_status};
          iopc_pkg::REG_IRQ_ENABLE: wb_dat_reg <= {29'h0, irq_enable_reg};
          iopc_pkg::REG_RESULT: wb_dat_reg <= {last_port_reg, 11'h000, state_reg, rsp_redirect_reg, rsp_fault_reg};
          iopc_pkg::REG_STACK_LO: wb_dat_reg <= rsp_data_reg[31:0];
          iopc_pkg::REG_STACK_HI: wb_dat_reg <= rsp_data_reg[63:32];
          iopc_pkg::REG_FAULT_COUNT: wb_dat_reg <= fault_count_reg;
          default: wb_dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_dat_o = wb_dat_reg;
  assign wb_ack_o = wb_ack_reg;
  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_fault = rsp_fault_reg;
  assign rsp_redirect = rsp_redirect_reg;
  assign rsp_data = rsp_data_reg;
  assign mem_rd_req = mem_rd_req_reg;
  assign mem_addr = mem_addr_reg;
  assign irq = irq_out;
endmodule : iopc_check

// ---- rtl/iopc_pkg.sv ----
// package: constants for the io port permission checker
package iopc_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TSS_BASE = 8'h04;
  localparam logic [7:0] REG_TSS_LIMIT = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;
  localparam logic [7:0] REG_STACK_LO = 8'h1c;
  localparam logic [7:0] REG_STACK_HI = 8'h20;
  localparam logic [7:0] REG_FAULT_COUNT = 8'h24;
  // control fields and reset values
  localparam int CTRL_ALL_PORTS_BIT = 0;
  localparam int CTRL_CHECK_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [31:0] TSS_LIMIT_RESET = 32'h0000_0067;
  // interrupt event bits
  localparam int IRQ_COUNT = 3;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_BASE_OVER_BIT = 1;
  localparam int IRQ_DONE_BIT = 2;
  // segment layout
  localparam logic [31:0] TSS_MAP_BASE_OFF = 32'h0000_0066;
  localparam logic [31:0] TSS_PRIV_STACK_OFF = 32'h0000_0004;
  localparam logic [31:0] TSS_INT_STACK_OFF = 32'h0000_0024;
  localparam logic [15:0] MAP_BASE_MAX = 16'hdfff;
  localparam logic [16:0] REDIR_MAP_BYTES = 17'h00020;
  localparam logic [3:0] PRIV_STACK_COUNT = 4'h3;
  localparam logic [3:0] STACK_INDEX_MAX = 4'h9;
  localparam logic [2:0] STACK_LAST_BYTE = 3'h7;
  // request kinds and access sizes
  localparam logic [1:0] KIND_PORT = 2'h0;
  localparam logic [1:0] KIND_REDIR = 2'h1;
  localparam logic [1:0] KIND_STACK = 2'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BASE_LO = 3'h1,
    ST_BASE_HI = 3'h3,
    ST_MAP_LO = 3'h2,
    ST_MAP_HI = 3'h6,
    ST_DONE = 3'h7,
    ST_STACK = 3'h5
  } iopc_state_t;
endpackage : iopc_pkg

// ---- rtl/iopc_perm_eval.sv ----
// module: permission bit window test over a two byte bitmap fetch
`timescale 1ns/10ps
module iopc_perm_eval (
  input wire logic [15:0] map_word,
  input wire logic [2:0] bit_sel,
  input wire logic [1:0] size,
  output logic deny
);
  logic [15:0] mask;
  logic [3:0] width;
  always_comb begin
    case (size)
      iopc_pkg::SIZE_WORD: width = 4'h2;
      iopc_pkg::SIZE_DWORD: width = 4'h4;
      default: width = 4'h1;
    endcase
  end
  // bit n of the window covers port n, up to four ports
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_mask
      assign mask[i] = (5'(i) >= {2'h0, bit_sel}) && (5'(i) < ({2'h0, bit_sel} + {1'h0, width}));
    end
  endgenerate
  assign deny = |(map_word & mask);
endmodule : iopc_perm_eval

// ---- rtl/iopc_irq.sv ----
// module: sticky event status with enable mask and level interrupt
`timescale 1ns/10ps
module iopc_irq #(
  parameter int N = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N-1:0] event_set,
  input wire logic [N-1:0] clear,
  input wire logic [N-1:0] enable,
  output logic [N-1:0] status,
  output logic irq
);
  logic [N-1:0] status_reg;
  logic irq_reg;
  // a set in the clearing cycle survives
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clear) | event_set;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(((status_reg & ~clear) | event_set) & enable);
    end
  end
  assign status = status_reg;
  assign irq = irq_reg;
endmodule : iopc_irq

// ---- sim/iopc_mem_model.sv ----
// partner: byte memory answering the checker's read port
`timescale 1ns/10ps
module iopc_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] slow,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_reg;
  // idle data toggles so a stale byte never passes for an answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5a;
      wait_reg <= 2'h0;
    end else if (!mem_ack && mem_rd_req && wait_reg >= slow) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[15:0]];
      wait_reg <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg <= (mem_rd_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule : iopc_mem_model

// ---- sim/iopc_check_chk.sv ----
// checker: port properties of the io port permission checker
`timescale 1ns/10ps
module iopc_check_chk #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [3:0] req_stack_index,
  input wire logic req_v86,
  input wire logic [1:0] req_cpl,
  input wire logic [1:0] req_io_privilege_level,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_fault,
  input wire logic mem_rd_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ack
);
  logic [31:0] base_reg;
  logic [2:0] ack_n_reg;
  logic port_reg;
  logic en_reg;
  logic taken;
  logic need;
  assign taken = req_valid && req_ready;
  assign need = req_v86 || (req_cpl > req_io_privilege_level);
  // shadows of segment base and check enable, so the expected fetch is known
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_reg <= 32'h0;
      en_reg <= iopc_pkg::CTRL_RESET[iopc_pkg::CTRL_CHECK_EN_BIT];
    end else if (wb_ack_o && wb_we_i && wb_adr_i == iopc_pkg::REG_TSS_BASE) begin
      base_reg <= wb_dat_i;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == iopc_pkg::REG_CTRL) begin
      en_reg <= wb_dat_i[iopc_pkg::CTRL_CHECK_EN_BIT];
    end
  end
  // acks counted per job; only the port job pairs its bytes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_reg <= 1'b0;
      ack_n_reg <= 3'h0;
    end else if (taken) begin
      port_reg <= req_kind == iopc_pkg::KIND_PORT;
      ack_n_reg <= 3'h0;
    end else begin
      ack_n_reg <= ack_n_reg + 3'(mem_ack);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_skip;
    taken && req_kind == iopc_pkg::KIND_PORT && !(need && en_reg) |=> !mem_rd_req ##[0:1] (rsp_valid && !rsp_fault);
  endproperty
  property p_map_fetch;
    taken && req_kind == iopc_pkg::KIND_PORT && need && en_reg |=>
      mem_rd_req && mem_addr == ADDR_W'(base_reg + iopc_pkg::TSS_MAP_BASE_OFF);
  endproperty
  property p_pair;
    port_reg && mem_ack && !ack_n_reg[0] && !ack_n_reg[2] |=> mem_rd_req && mem_addr == $past(mem_addr) + 1'b1;
  endproperty
  property p_hold;
    mem_rd_req && !mem_ack |=> mem_rd_req && $stable(mem_addr);
  endproperty
  property p_stack_bad;
    taken && req_kind == iopc_pkg::KIND_STACK && req_stack_index > iopc_pkg::STACK_INDEX_MAX |->
      ##[1:2] (rsp_valid && rsp_fault);
  endproperty
  property p_rsp_once;
    rsp_valid |=> !rsp_valid;
  endproperty
  property p_busy;
    taken |=> !req_ready;
  endproperty
  property p_fault_hold;
    !rsp_valid |-> $stable(rsp_fault);
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus cycle not acked");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_skip: assert property (p_skip) else $error("check not skipped");
  a_map_fetch: assert property (p_map_fetch) else $error("bad offset fetch");
  a_pair: assert property (p_pair) else $error("second byte not next");
  a_hold: assert property (p_hold) else $error("read request not held");
  a_stack_bad: assert property (p_stack_bad) else $error("bad stack index passed");
  a_rsp_once: assert property (p_rsp_once) else $error("response too long");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_fault_hold: assert property (p_fault_hold) else $error("fault moved between responses");
  c_fault: cover property (rsp_valid && rsp_fault);
  c_skip: cover property (taken && !need);
  c_stack: cover property (taken && req_kind == iopc_pkg::KIND_STACK);
endmodule : iopc_check_chk
bind iopc_check iopc_check_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .req_valid, .req_kind, .req_stack_index, .req_v86, .req_cpl, .req_io_privilege_level,
  .req_ready, .rsp_valid, .rsp_fault, .mem_rd_req, .mem_addr, .mem_ack);

// ---- sim/testbench.sv ----
// testbench: directed and random checks of the io port permission checker
`timescale 1ns/10ps
module testbench;
  localparam int BASE = 32'h1000;
  localparam int LIM = 32'h108;
  logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid, req_v86, req_ready, rsp_valid;
  logic rsp_fault, rsp_redirect, mem_rd_req, mem_ack, irq;
  logic [7:0] wb_adr_i, req_vector, mem_rdata;
  logic [3:0] wb_sel_i, req_stack_index;
  logic [31:0] wb_dat_i, wb_dat_o, mem_addr, rd;
  logic [1:0] req_kind, req_size, req_cpl, req_io_privilege_level, slow, ctrl, ef;
  logic [15:0] req_port;
  logic [63:0] rsp_data, exp_d;
  logic [2:0] st_m;
  int n_mismatch, tests_run, seed, p, s, nf;
  iopc_check dut (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .req_valid, .req_kind, .req_port, .req_size, .req_vector, .req_stack_index,
    .req_v86, .req_cpl, .req_io_privilege_level, .req_ready, .rsp_valid, .rsp_fault, .rsp_redirect, .rsp_data,
    .mem_rd_req, .mem_addr, .mem_ack, .mem_rdata, .irq);
  iopc_mem_model u_mem (.clk, .arst_n, .mem_rd_req, .mem_addr, .slow, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // about 1300 cycles expected; the margin allows for slow memory
  initial begin
    #800000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word(64'(got), 64'(exp));
  endtask : cmp_bit
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) cmp_bit(1'b0, 1'b1);
  endtask : wb
  // port doubles as vector; memory speed drawn per request
  task automatic rq(input logic [1:0] k, input int p, input int s, input int ix, input int v, input int c, input int io);
    int n;
    n = 0;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) cmp_bit(1'b0, 1'b1);
    req_valid <= 1'b1;
    req_kind <= k;
    req_port <= 16'(p);
    req_vector <= 8'(p);
    req_size <= 2'(s);
    req_stack_index <= 4'(ix);
    req_v86 <= 1'(v);
    req_cpl <= 2'(c);
    req_io_privilege_level <= 2'(io);
    slow <= 2'($unsigned($random(seed)) % 3);
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) cmp_bit(1'b0, 1'b1);
  endtask : rq
  function automatic logic [7:0] mb(input int a);
    return u_mem.mem[BASE + a];
  endfunction : mb
  // one port check: {offset above the cap, fault}
  function automatic logic [1:0] exp_port(input int p, input int s, input bit need);
    int ofs;
    int idx;
    logic [15:0] pair;
    ofs = {mb(32'h67), mb(32'h66)};
    idx = ofs + p / 8;
    pair = {mb(idx + 1), mb(idx)};
    if (!need || !ctrl[1]) return 2'h0;
    if (ctrl[0] && ofs > 32'hdfff) return 2'h3;
    if (idx + 1 > LIM) return 2'h1;
    return {1'b0, |(pair >> (p % 8) & ((16'h1 << (1 << s)) - 16'h1))};
  endfunction : exp_port
  initial begin
    seed = 70;
    n_mismatch = 0;
    tests_run = 0;
    nf = 0;
    ctrl = 2'h3;
    arst_n = 1'b0;
    wb_sel_i = 4'hf;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, req_valid, req_kind, req_port} = '0;
    {req_size, req_vector, req_stack_index, req_v86, req_cpl, req_io_privilege_level, slow} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    wb(1'b0, iopc_pkg::REG_CTRL, 32'h0);
    cmp_word(64'(rd), 64'(iopc_pkg::CTRL_RESET));
    wb(1'b0, iopc_pkg::REG_TSS_LIMIT, 32'h0);
    cmp_word(64'(rd), 64'(iopc_pkg::TSS_LIMIT_RESET));
    wb(1'b0, 8'hfc, 32'h0);
    cmp_word(64'(rd), 64'h0);
    wb(1'b1, iopc_pkg::REG_TSS_BASE, BASE);
    wb(1'b1, iopc_pkg::REG_TSS_LIMIT, LIM);
    wb(1'b1, iopc_pkg::REG_IRQ_ENABLE, 32'h1);
    for (int i = 4; i < LIM; i++) u_mem.mem[BASE + i] = 8'($random(seed));
    u_mem.mem[BASE + 32'h66] = 8'h88;
    u_mem.mem[BASE + 32'h67] = 8'h00;
    u_mem.mem[BASE + LIM] = 8'hff;
    // ports reach past the last entry so limit faults mix in
    st_m = 3'h0;
    repeat (60) begin
      p = $unsigned($random(seed)) % 32'h500;
      s = $unsigned($random(seed)) % 3;
      rq(iopc_pkg::KIND_PORT, p, s, 0, $random(seed), $random(seed), $random(seed));
      ef = exp_port(p, s, req_v86 || req_cpl > req_io_privilege_level);
      cmp_bit(rsp_fault, ef[0]);
      st_m = st_m | {1'b1, ef};
      nf += ef[0];
    end
    wb(1'b1, iopc_pkg::REG_IRQ_STATUS, 32'h0);
    wb(1'b0, iopc_pkg::REG_IRQ_STATUS, 32'h0);
    cmp_word(64'(rd), 64'(st_m));
    cmp_bit(irq, st_m[0]);
    wb(1'b1, iopc_pkg::REG_IRQ_ENABLE, 32'h0);
    wb(1'b0, iopc_pkg::REG_IRQ_CLEAR, 32'h0);
    cmp_word(64'(rd), 64'h0);
    cmp_bit(irq, 1'b0);
    wb(1'b1, iopc_pkg::REG_IRQ_ENABLE, 32'h1);
    wb(1'b1, iopc_pkg::REG_IRQ_CLEAR, 32'h7);
    wb(1'b0, iopc_pkg::REG_IRQ_STATUS, 32'h0);
    cmp_word(64'(rd), 64'h0);
    cmp_bit(irq, 1'b0);
    for (int i = 0; i <= 10; i++) begin
      rq(iopc_pkg::KIND_STACK, 0, 0, i, 0, 0, 0);
      for (int b = 0; b < 8; b++) exp_d[8*b +: 8] = mb((i < 3 ? 4 + 8 * i : 32'h24 + 8 * (i - 3)) + b);
      cmp_bit(rsp_fault, 1'(i > 9));
      nf += (i > 9);
      if (i <= 9) cmp_word(rsp_data, exp_d);
      if (i == 9) begin
        wb(1'b0, iopc_pkg::REG_STACK_HI, 32'h0);
        cmp_word(64'(rd), 64'(exp_d[63:32]));
      end
    end
    for (int i = 0; i < 8; i++) begin
      p = (i == 0) ? 0 : (i == 1) ? 255 : $unsigned($random(seed)) % 256;
      rq(iopc_pkg::KIND_REDIR, p, 0, 0, 1, 3, 0);
      cmp_bit(rsp_redirect, 1'(mb(32'h68 + p / 8) >> (p % 8)));
    end
    for (int j = 0; j < 4; j++) begin
      ctrl = (j == 2) ? 2'h2 : (j == 3) ? 2'h1 : 2'h3;
      wb(1'b1, iopc_pkg::REG_CTRL, 32'(ctrl));
      wb(1'b1, iopc_pkg::REG_IRQ_CLEAR, 32'h7);
      u_mem.mem[BASE + 32'h66] = (j == 1) ? 8'hff : 8'h00;
      u_mem.mem[BASE + 32'h67] = (j == 1) ? 8'hdf : 8'he0;
      rq(iopc_pkg::KIND_PORT, 32'h10, 0, 0, 1, 0, 0);
      ef = exp_port(32'h10, 0, 1'b1);
      cmp_bit(rsp_fault, ef[0]);
      nf += ef[0];
      wb(1'b0, iopc_pkg::REG_IRQ_STATUS, 32'h0);
      cmp_word(64'(rd), {61'h0, 1'b1, ef});
    end
    // last fault was port 10h, last answer with check disabled was clean
    wb(1'b0, iopc_pkg::REG_FAULT_COUNT, 32'h0);
    cmp_word(64'(rd), 64'(nf));
    wb(1'b0, iopc_pkg::REG_RESULT, 32'h0);
    cmp_word(64'(rd), 64'h0010_0000);
    close_out();
  end
endmodule : testbench
